// [common/ufc_params.svh]
// Constants for the flow-character and pin register slice.
// Assumes a byte-wide register port with a 5-bit register index.
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH

`define UFC_ADDR_W        5
`define UFC_OFS_RESUME1   5'h14
`define UFC_OFS_RESUME2   5'h15
`define UFC_OFS_PAUSE1    5'h16
`define UFC_OFS_PAUSE2    5'h17
`define UFC_OFS_PIN_CFG   5'h18
`define UFC_OFS_PIN_LVL   5'h19
`define UFC_REG_RESET     8'h00
`define UFC_NIB_RESET     4'h0
`define UFC_SWF_EN_BIT    3
`define UFC_SWF_ADDR_BIT  2
`define UFC_SWF_RX_HI     5
`define UFC_SWF_RX_LO     4
`define UFC_CFG_DIR_HI    3
`define UFC_CFG_OD_HI     7
`define UFC_CFG_OD_LO     4
`define UFC_LVL_IN_HI     7
`define UFC_LVL_IN_LO     4
`define UFC_PINS          4

`endif

// [common/ufc_pkg.sv]
// Types shared by the flow-character and pin register slice.
// Assumes ufc_params.svh is on the include path.
`include "ufc_params.svh"

package ufc_pkg;

  typedef logic [7:0] ufc_byte_type;
  typedef logic [`UFC_ADDR_W-1:0] ufc_addr_type;
  typedef logic [`UFC_PINS-1:0] ufc_pins_type;

  // Receive comparison selected by the two receiver flow bits
  typedef enum logic [1:0] {
    UFC_MATCH_NONE,
    UFC_MATCH_FIRST,
    UFC_MATCH_SECOND,
    UFC_MATCH_PAIR
  } ufc_match_type;

endpackage : ufc_pkg

// [hdl/ufc_pin_sync.sv]
// Three-stage pin input synchroniser, one lane per pin.
// Assumes pins are asynchronous to core_clk; output moves only when
// the second and third stages agree.
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_pin_sync
  import ufc_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Pins and filtered levels
  input  wire ufc_pins_type pin_raw,
  output ufc_pins_type      pin_level
);

  genvar lane;
  generate
    for (lane = 0; lane < `UFC_PINS; lane++) begin : g_lane
      logic stage_a;
      logic stage_b;
      logic stage_c;

      // Stage a feeds stage b only, to keep metastability contained
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          stage_a <= 1'b0;
          stage_b <= 1'b0;
          stage_c <= 1'b0;
        end else begin
          stage_a <= pin_raw[lane];
          stage_b <= stage_a;
          stage_c <= stage_b;
        end
      end

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          pin_level[lane] <= 1'b0;
        end else if (stage_b == stage_c) begin
          pin_level[lane] <= stage_c;
        end
      end
    end
  endgenerate

endmodule : ufc_pin_sync

// [hdl/ufc_regs.sv]
// One channel's flow-character and general-purpose pin registers.
// Assumes the host interface delivers one-cycle byte read/write strobes
// on core_clk; flow and mode settings come from registers elsewhere on
// the same clock; received characters arrive as one-cycle strobes.
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_regs
  import ufc_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset,
  // Register port
  input  wire logic          reg_wr_en,
  input  wire logic          reg_rd_en,
  input  wire ufc_addr_type  reg_addr,
  input  wire ufc_byte_type  reg_wdata,
  output ufc_byte_type       reg_rdata,
  output logic               reg_rd_valid,
  // Settings held elsewhere
  input  wire ufc_byte_type  soft_flow_settings,
  input  wire logic          special_detect_enable,
  // Received characters
  input  wire logic          rx_char_valid,
  input  wire ufc_byte_type  rx_char,
  output logic               flow_resume_seen,
  output logic               flow_pause_seen,
  output logic               special_char_seen,
  output logic               rx_char_drop,
  output logic               rx_char_keep,
  // Channel pins
  input  wire ufc_pins_type  gpio_in,
  output ufc_pins_type       gpio_out,
  output ufc_pins_type       gpio_oe_n
);

  import ufc_pkg::*;

  // Every check below runs on core_clk and rests while reset is high
  default clocking chk_clk @(posedge core_clk);
  endclocking
  default disable iff (reset);

  ufc_byte_type  resume_char_first;
  ufc_byte_type  resume_char_second;
  ufc_byte_type  pause_char_first;
  ufc_byte_type  pause_char_second;
  ufc_byte_type  pin_config;
  ufc_pins_type  pin_output_level;
  ufc_pins_type  pin_input_level;
  ufc_pins_type  pin_direction_sel;
  ufc_pins_type  pin_open_drain_sel;
  ufc_byte_type  prev_char;
  logic          prev_valid;
  ufc_match_type match_mode;
  logic          soft_flow_enable;
  logic          pin_address_enable;
  logic          flow_active;
  ufc_byte_type  addr_char;
  logic          next_resume;
  logic          next_pause;
  logic          next_special;

  assign pin_direction_sel  = pin_config[`UFC_CFG_DIR_HI:0];
  assign pin_open_drain_sel = pin_config[`UFC_CFG_OD_HI:`UFC_CFG_OD_LO];
  assign soft_flow_enable   = soft_flow_settings[`UFC_SWF_EN_BIT];
  assign pin_address_enable = soft_flow_settings[`UFC_SWF_ADDR_BIT];
  assign flow_active        = soft_flow_enable &&
                              (match_mode != UFC_MATCH_NONE);
  // Address form ignores the stored low nibble of the second pause char
  assign addr_char = {pause_char_second[7:4], pin_input_level};

  // Pin levels pass a three-stage filter before anyone looks at them
  ufc_pin_sync u_pin_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .pin_raw   (gpio_in),
    .pin_level (pin_input_level)
  );

  // Register writes; input half of the level register is not writable
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      resume_char_first  <= `UFC_REG_RESET;
      resume_char_second <= `UFC_REG_RESET;
      pause_char_first   <= `UFC_REG_RESET;
      pause_char_second  <= `UFC_REG_RESET;
      pin_config         <= `UFC_REG_RESET;
      pin_output_level   <= `UFC_NIB_RESET;
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        `UFC_OFS_RESUME1: resume_char_first  <= reg_wdata;
        `UFC_OFS_RESUME2: resume_char_second <= reg_wdata;
        `UFC_OFS_PAUSE1:  pause_char_first   <= reg_wdata;
        `UFC_OFS_PAUSE2:  pause_char_second  <= reg_wdata;
        `UFC_OFS_PIN_CFG: pin_config         <= reg_wdata;
        `UFC_OFS_PIN_LVL: pin_output_level   <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Reads answer one cycle later; unmapped indices read zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata    <= `UFC_REG_RESET;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        unique case (reg_addr)
          `UFC_OFS_RESUME1: reg_rdata <= resume_char_first;
          `UFC_OFS_RESUME2: reg_rdata <= resume_char_second;
          `UFC_OFS_PAUSE1:  reg_rdata <= pause_char_first;
          `UFC_OFS_PAUSE2:  reg_rdata <= pause_char_second;
          `UFC_OFS_PIN_CFG: reg_rdata <= pin_config;
          `UFC_OFS_PIN_LVL:
            reg_rdata <= {pin_input_level, pin_output_level};
          default:          reg_rdata <= `UFC_REG_RESET;
        endcase
      end
    end
  end

  // Pin drivers; local bit n drives this channel's nth pin
  genvar pin;
  generate
    for (pin = 0; pin < `UFC_PINS; pin++) begin : g_pin
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          gpio_out[pin]  <= 1'b0;
          gpio_oe_n[pin] <= 1'b1;
        end else if (!pin_direction_sel[pin]) begin
          // Pulldown is in the pad; logic just lets go
          gpio_out[pin]  <= 1'b0;
          gpio_oe_n[pin] <= 1'b1;
        end else if (pin_open_drain_sel[pin]) begin
          // Open drain only ever pulls low; a high needs a pullup
          gpio_out[pin]  <= 1'b0;
          gpio_oe_n[pin] <= pin_output_level[pin];
        end else begin
          gpio_out[pin]  <= pin_output_level[pin];
          gpio_oe_n[pin] <= 1'b0;
        end
      end
    end
  endgenerate

  // Receiver comparison mode; special detection pins flow to first pair
  always_comb begin
    unique case (soft_flow_settings[`UFC_SWF_RX_HI:`UFC_SWF_RX_LO])
      2'b10:   match_mode = UFC_MATCH_FIRST;
      2'b01:   match_mode = special_detect_enable ? UFC_MATCH_FIRST
                                                  : UFC_MATCH_SECOND;
      2'b11:   match_mode = special_detect_enable ? UFC_MATCH_FIRST
                                                  : UFC_MATCH_PAIR;
      default: match_mode = UFC_MATCH_NONE;
    endcase
  end

  // Flow character match on the incoming character
  always_comb begin
    next_resume = 1'b0;
    next_pause  = 1'b0;
    if (flow_active) begin
      unique case (match_mode)
        UFC_MATCH_FIRST: begin
          next_resume = (rx_char == resume_char_first);
          next_pause  = (rx_char == pause_char_first);
        end
        UFC_MATCH_SECOND: begin
          next_resume = (rx_char == resume_char_second);
          next_pause  = (rx_char == pause_char_second);
        end
        UFC_MATCH_PAIR: begin
          // Low byte arrives first, high byte completes the sequence
          next_resume = prev_valid && (prev_char == resume_char_first)
                        && (rx_char == resume_char_second);
          next_pause  = prev_valid && (prev_char == pause_char_first)
                        && (rx_char == pause_char_second);
        end
        UFC_MATCH_NONE: ;
      endcase
    end
  end

  // Special character match
  always_comb begin
    next_special = 1'b0;
    if (special_detect_enable) begin
      next_special = (rx_char == resume_char_second) ||
                     (pin_address_enable ? (rx_char == addr_char)
                                         : (rx_char == pause_char_second));
      if (!soft_flow_enable) begin
        next_special = next_special ||
                       (rx_char == resume_char_first) ||
                       (rx_char == pause_char_first);
      end
    end
  end

  // Last received character, kept for the pair sequence
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_char  <= `UFC_REG_RESET;
      prev_valid <= 1'b0;
    end else if (rx_char_valid) begin
      prev_char  <= rx_char;
      prev_valid <= 1'b1;
    end
  end

  // Per-character results, one cycle after the character strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flow_resume_seen  <= 1'b0;
      flow_pause_seen   <= 1'b0;
      special_char_seen <= 1'b0;
      rx_char_drop      <= 1'b0;
      rx_char_keep      <= 1'b0;
    end else begin
      flow_resume_seen  <= rx_char_valid && next_resume;
      flow_pause_seen   <= rx_char_valid && next_pause;
      special_char_seen <= rx_char_valid && next_special;
      rx_char_drop <= rx_char_valid && (next_resume || next_pause);
      rx_char_keep <= rx_char_valid && !(next_resume || next_pause);
    end
  end

  // Checks

  a_read_answer: assert property (
    reg_rd_en |=> reg_rd_valid ##1 !reg_rd_valid || $past(reg_rd_en))
    else $error("read answer not one cycle after request");

  a_cfg_write: assert property (
    reg_wr_en && reg_addr == `UFC_OFS_PIN_CFG
    |=> pin_config == $past(reg_wdata))
    else $error("pin configuration write lost");

  a_level_write: assert property (
    reg_wr_en && reg_addr == `UFC_OFS_PIN_LVL
    |=> pin_output_level == $past(reg_wdata[3:0]))
    else $error("output level write lost");

  a_dir_write: assert property (
    reg_wr_en && reg_addr == `UFC_OFS_PIN_CFG ##1 !reg_wr_en
    |=> (gpio_oe_n | pin_direction_sel) == 4'hF)
    else $error("pin drives against direction setting");

  // Drivers lag the settings by one edge, so compare against $past
  a_input_float: assert property (
    $stable(pin_config)
    |=> ((~gpio_oe_n) & (~$past(pin_direction_sel))) == 4'h0)
    else $error("input pin is being driven");

  a_od_no_high: assert property (
    $stable(pin_config)
    |=> ($past(pin_open_drain_sel) & gpio_out) == 4'h0)
    else $error("open-drain pin drives high");

  a_pp_level: assert property (
    $stable(pin_config) && $stable(pin_output_level)
    |=> ((~gpio_oe_n) & (~$past(pin_open_drain_sel))
         & (gpio_out ^ $past(pin_output_level))) == 4'h0)
    else $error("push-pull pin level differs from register");

  a_in_read: assert property (
    reg_rd_en && reg_addr == `UFC_OFS_PIN_LVL
    |=> reg_rdata[7:4] == $past(pin_input_level))
    else $error("level read does not show pin inputs");

  a_resume_first: assert property (
    rx_char_valid && soft_flow_enable && match_mode == UFC_MATCH_FIRST
    && rx_char == resume_char_first |=> flow_resume_seen && rx_char_drop)
    else $error("first resume character missed");

  a_second_resume: assert property (
    rx_char_valid && flow_active && match_mode == UFC_MATCH_SECOND
    && rx_char == resume_char_second |=> flow_resume_seen)
    else $error("alternate resume character missed");

  a_pause_first: assert property (
    rx_char_valid && flow_active && match_mode == UFC_MATCH_FIRST
    && rx_char == pause_char_first |=> flow_pause_seen && rx_char_drop)
    else $error("first pause character missed");

  // Pair checks cover characters that arrive one idle cycle apart
  a_resume_pair: assert property (
    rx_char_valid && flow_active && match_mode == UFC_MATCH_PAIR
    && rx_char == resume_char_first ##1 !rx_char_valid
    ##1 rx_char_valid && flow_active && match_mode == UFC_MATCH_PAIR
    && rx_char == resume_char_second |=> flow_resume_seen)
    else $error("resume pair sequence missed");

  a_pair_pause: assert property (
    rx_char_valid && flow_active && match_mode == UFC_MATCH_PAIR
    && rx_char == pause_char_first ##1 !rx_char_valid
    ##1 rx_char_valid && flow_active && match_mode == UFC_MATCH_PAIR
    && rx_char == pause_char_second |=> flow_pause_seen)
    else $error("pause pair sequence missed");

  a_special_all: assert property (
    rx_char_valid && special_detect_enable && !soft_flow_enable
    && rx_char == pause_char_first |=> special_char_seen)
    else $error("special character missed with flow off");

  a_split_flow: assert property (
    rx_char_valid && special_detect_enable && soft_flow_enable
    && rx_char != resume_char_first && rx_char != pause_char_first
    |=> !flow_resume_seen && !flow_pause_seen)
    else $error("second pair used for flow with detection on");

  a_pin_addr: assert property (
    rx_char_valid && special_detect_enable && pin_address_enable
    && rx_char == {pause_char_second[7:4], pin_input_level}
    |=> special_char_seen)
    else $error("pin address special character missed");

  a_drop_only: assert property (
    rx_char_drop |-> (flow_resume_seen || flow_pause_seen)
    && !rx_char_keep)
    else $error("character dropped without flow match");

  a_one_outcome: assert property (
    rx_char_valid |=> rx_char_drop != rx_char_keep)
    else $error("character not given exactly one outcome");

  a_quiet_idle: assert property (
    !rx_char_valid |=> !rx_char_drop && !rx_char_keep
    && !flow_resume_seen && !flow_pause_seen && !special_char_seen)
    else $error("result pulse without a received character");

endmodule : ufc_regs

// [test/ufc_pad_model.sv]
// Board-side model of one channel's four pins: pad resolution,
// external pull resistors and an optional external driver.
// Assumes open-drain pins get a pull-up and input pins a weak pulldown.
`timescale 1ns/1ps

module ufc_pad_model
  import ufc_pkg::*;
(
  // Device side
  input  wire ufc_pins_type gpio_out,
  input  wire ufc_pins_type gpio_oe_n,
  // Board side
  input  wire ufc_pins_type ext_en,
  input  wire ufc_pins_type ext_val,
  input  wire ufc_pins_type pull_up,
  output ufc_pins_type      pin_level
);
  always_comb begin
    for (int i = 0; i < $bits(ufc_pins_type); i++) begin
      if (!gpio_oe_n[i]) begin
        pin_level[i] = gpio_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else begin
        // Released pin settles to its pull, never to the last value
        pin_level[i] = pull_up[i];
      end
    end
  end
endmodule : ufc_pad_model

// [test/ufc_regs_tb.sv]
// Self-checking bench for the flow-character and pin register slice.
// Assumes ufc_regs behind a strobe register port and the pad model.
`timescale 1ns/1ps

module ufc_regs_tb;
  import ufc_pkg::*;
  logic          core_clk              = 1'b0;
  logic          reset                 = 1'b1;
  logic          reg_wr_en             = 1'b0;
  logic          reg_rd_en             = 1'b0;
  ufc_addr_type  reg_addr              = 5'h00;
  ufc_byte_type  reg_wdata             = 8'h00;
  ufc_byte_type  soft_flow_settings    = 8'h00;
  logic          special_detect_enable = 1'b0;
  logic          rx_char_valid         = 1'b0;
  ufc_byte_type  rx_char               = 8'h00;
  ufc_pins_type  ext_en                = 4'h0;
  ufc_pins_type  ext_val               = 4'h0;
  ufc_pins_type  pull_up               = 4'h0;
  ufc_byte_type  reg_rdata;
  logic          reg_rd_valid;
  logic          flow_resume_seen;
  logic          flow_pause_seen;
  logic          special_char_seen;
  logic          rx_char_drop;
  logic          rx_char_keep;
  ufc_pins_type  gpio_in;
  ufc_pins_type  gpio_out;
  ufc_pins_type  gpio_oe_n;
  int            errors                = 0;
  int            comparisons           = 0;
  ufc_byte_type  dut_chars [4] = '{8'h11, 8'h12, 8'h13, 8'h5C};

  always #2.5 core_clk = ~core_clk;

  ufc_regs dut (
    .core_clk(core_clk), .reset(reset),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .soft_flow_settings(soft_flow_settings),
    .special_detect_enable(special_detect_enable),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .flow_resume_seen(flow_resume_seen), .flow_pause_seen(flow_pause_seen),
    .special_char_seen(special_char_seen), .rx_char_drop(rx_char_drop),
    .rx_char_keep(rx_char_keep), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n)
  );

  ufc_pad_model pads (
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pull_up(pull_up), .pin_level(gpio_in)
  );

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // Idle cycle at the end keeps strobes from toggling in one time step
  task automatic wr_reg(input ufc_addr_type a, input ufc_byte_type d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    cyc(1);
    reg_wr_en = 1'b0;
    cyc(1);
  endtask : wr_reg

  task automatic rd_chk(input ufc_addr_type a, input ufc_byte_type exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    cyc(1);
    reg_rd_en = 1'b0;
    check("reg_rd_valid", {7'h00, reg_rd_valid}, 8'h01);
    check("reg_rdata", reg_rdata, exp);
    cyc(1);
  endtask : rd_chk

  task automatic pins_chk(input ufc_pins_type oe_n, input ufc_pins_type out);
    cyc(6);
    check("gpio_oe_n", {4'h0, gpio_oe_n}, {4'h0, oe_n});
    check("gpio_out", {4'h0, gpio_out}, {4'h0, out});
  endtask : pins_chk

  // Flags: resume, pause, special, drop, keep
  task automatic rx_chk(input ufc_byte_type c, input logic [4:0] exp);
    rx_char = c;
    rx_char_valid = 1'b1;
    cyc(1);
    rx_char_valid = 1'b0;
    check("rx_flags", {3'h0, flow_resume_seen, flow_pause_seen,
          special_char_seen, rx_char_drop, rx_char_keep}, {3'h0, exp});
    cyc(1);
  endtask : rx_chk

  task automatic t_regs();
    pins_chk(4'hF, 4'h0);
    for (int a = 'h14; a <= 'h19; a++) rd_chk(a[4:0], 8'h00);
    wr_reg(5'h14, 8'h11);
    wr_reg(5'h15, 8'h12);
    wr_reg(5'h16, 8'h13);
    wr_reg(5'h17, 8'h5C);
    wr_reg(5'h1A, 8'hFF);
    rd_chk(5'h14, 8'h11);
    rd_chk(5'h17, 8'h5C);
    rd_chk(5'h1A, 8'h00);
    wr_reg(5'h19, 8'hF5);
    rd_chk(5'h19, 8'h05);
    pins_chk(4'hF, 4'h0);
  endtask : t_regs

  task automatic t_pins();
    pull_up = 4'hF;
    wr_reg(5'h18, 8'hCF);
    pins_chk(4'b0100, 4'b0001);
    rd_chk(5'h19, 8'h55);
    wr_reg(5'h19, 8'h0A);
    pins_chk(4'b1000, 4'b0010);
    pull_up = 4'h0;
    ext_en = 4'hF;
    ext_val = 4'hA;
    wr_reg(5'h18, 8'h00);
    pins_chk(4'hF, 4'h0);
    rd_chk(5'h19, 8'hAA);
  endtask : t_pins

  task automatic t_flow();
    soft_flow_settings = 8'h28;
    rx_chk(8'h11, 5'b10010);
    rx_chk(8'h13, 5'b01010);
    rx_chk(8'h12, 5'b00001);
    soft_flow_settings = 8'h18;
    rx_chk(8'h12, 5'b10010);
    rx_chk(8'h5C, 5'b01010);
    rx_chk(8'h11, 5'b00001);
    soft_flow_settings = 8'h38;
    rx_chk(8'h11, 5'b00001);
    rx_chk(8'h12, 5'b10010);
    rx_chk(8'h13, 5'b00001);
    rx_chk(8'h5C, 5'b01010);
  endtask : t_flow

  task automatic t_special();
    soft_flow_settings = 8'h00;
    special_detect_enable = 1'b1;
    foreach (dut_chars[i]) rx_chk(dut_chars[i], 5'b00101);
    rx_chk(8'h77, 5'b00001);
    soft_flow_settings = 8'h28;
    rx_chk(8'h11, 5'b10010);
    rx_chk(8'h13, 5'b01010);
    rx_chk(8'h12, 5'b00101);
    rx_chk(8'h5C, 5'b00101);
    soft_flow_settings = 8'h2C;
    rx_chk(8'h5A, 5'b00101);
    rx_chk(8'h5C, 5'b00001);
  endtask : t_special

  // Mid-run reset while all pins drive: registers clear, drivers let go
  task automatic t_reset();
    wr_reg(5'h18, 8'h0F);
    pins_chk(4'h0, 4'hA);
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    pins_chk(4'hF, 4'h0);
    rd_chk(5'h14, 8'h00);
    rd_chk(5'h18, 8'h00);
    rd_chk(5'h19, 8'hA0);
  endtask : t_reset

  task automatic conclude();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_regs();
    t_pins();
    t_flow();
    t_special();
    t_reset();
    conclude();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #100000;
    errors++;
    conclude();
  end
endmodule : ufc_regs_tb
